// file: core/alt_core.sv
// Accumulator with the load transfers from control registers and X/Y.
// Assumes one instruction per clock while instr_valid_i is high and that
// source register values are held stable by their owners.
//
// Added by the designer: the strobed register port and the register addresses.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// - Interrupt-control-read-one opcode copies interrupt control register one into accumulator.
// - Interrupt-control-read-two opcode copies interrupt control register two into accumulator.
// - Four timer-control-read opcodes each copy one timer control register into accumulator.
// - Load-from-X opcode copies register X into accumulator in one cycle.
// - Load-from-Y opcode copies register Y into accumulator in one cycle.
module alt_core (
	input  wire logic                        clock_i,
	input  wire logic                        sys_rst_i,
	input  wire logic [alt_pkg::INSTR_W-1:0] instr_i,
	input  wire logic                        instr_valid_i,
	input  wire logic [alt_pkg::DATA_W-1:0]  int_ctrl_reg_one_i,
	input  wire logic [alt_pkg::DATA_W-1:0]  int_ctrl_reg_two_i,
	input  wire logic [alt_pkg::DATA_W-1:0]  timer_ctrl_reg_one_i,
	input  wire logic [alt_pkg::DATA_W-1:0]  timer_ctrl_reg_two_i,
	input  wire logic [alt_pkg::DATA_W-1:0]  timer_ctrl_reg_three_i,
	input  wire logic [alt_pkg::DATA_W-1:0]  timer_ctrl_reg_four_i,
	input  wire logic [alt_pkg::DATA_W-1:0]  reg_x_i,
	input  wire logic [alt_pkg::DATA_W-1:0]  reg_y_i,
	input  wire logic                        acc_wr_i,
	input  wire logic [alt_pkg::DATA_W-1:0]  acc_wr_data_i,
	input  wire logic                        carry_wr_i,
	input  wire logic                        carry_wr_data_i,
	input  wire logic                        skip_req_i,
	input  wire logic [alt_pkg::ADDR_W-1:0]  reg_addr_i,
	input  wire logic [alt_pkg::REG_W-1:0]   reg_wdata_i,
	input  wire logic                        reg_we_i,
	input  wire logic                        reg_re_i,
	output logic      [alt_pkg::REG_W-1:0]   reg_rdata_o,
	output logic      [alt_pkg::DATA_W-1:0]  acc_o,
	output logic                             carry_flag_o,
	output logic                             skip_o,
	output logic                             xfer_done_o
);

	// ==================================================================
	// State.
	alt_pkg::alt_state_t state_r;
	alt_pkg::alt_state_t state_nxt;
	alt_pkg::alt_src_t   src;
	logic                hit;

	// ==================================================================
	// Decoder.
	alt_decode alt_decode_i (
		.instr_i (instr_i),
		.valid_i (instr_valid_i),
		.en_i    (state_r.en),
		.src_o   (src),
		.hit_o   (hit)
	);

	// ==================================================================
	// Source select.
	function automatic logic [alt_pkg::DATA_W-1:0] src_mux(
		input alt_pkg::alt_src_t          s,
		input logic [alt_pkg::DATA_W-1:0] int_one,
		input logic [alt_pkg::DATA_W-1:0] int_two,
		input logic [alt_pkg::DATA_W-1:0] tmr_one,
		input logic [alt_pkg::DATA_W-1:0] tmr_two,
		input logic [alt_pkg::DATA_W-1:0] tmr_three,
		input logic [alt_pkg::DATA_W-1:0] tmr_four,
		input logic [alt_pkg::DATA_W-1:0] x_val,
		input logic [alt_pkg::DATA_W-1:0] y_val
	);
		case (s)
			alt_pkg::ALT_SRC_INT_ONE:   src_mux = int_one;
			alt_pkg::ALT_SRC_INT_TWO:   src_mux = int_two;
			alt_pkg::ALT_SRC_TMR_ONE:   src_mux = tmr_one;
			alt_pkg::ALT_SRC_TMR_TWO:   src_mux = tmr_two;
			alt_pkg::ALT_SRC_TMR_THREE: src_mux = tmr_three;
			alt_pkg::ALT_SRC_TMR_FOUR:  src_mux = tmr_four;
			alt_pkg::ALT_SRC_X:         src_mux = x_val;
			alt_pkg::ALT_SRC_Y:         src_mux = y_val;
			default:                    src_mux = alt_pkg::RST_ACC;
		endcase
	endfunction : src_mux

	// ==================================================================
	// Next state.
	always_comb begin
		state_nxt      = state_r;
		state_nxt.done = hit;
		state_nxt.rdata = alt_pkg::RST_RDATA;
		if (hit) begin
			state_nxt.acc = src_mux(src, int_ctrl_reg_one_i, int_ctrl_reg_two_i,
				timer_ctrl_reg_one_i, timer_ctrl_reg_two_i, timer_ctrl_reg_three_i,
				timer_ctrl_reg_four_i, reg_x_i, reg_y_i);
			state_nxt.skip = 1'b0;
		end else begin
			if (acc_wr_i) begin
				state_nxt.acc = acc_wr_data_i;
			end
			if (carry_wr_i) begin
				state_nxt.carry = carry_wr_data_i;
			end
			state_nxt.skip = skip_req_i;
		end
		if (reg_we_i && reg_addr_i == alt_pkg::CTRL_OFS) begin
			state_nxt.en = reg_wdata_i[alt_pkg::CTRL_EN_BIT];
		end
		if (reg_re_i) begin
			case (reg_addr_i)
				alt_pkg::CTRL_OFS: begin
					state_nxt.rdata[alt_pkg::CTRL_EN_BIT] = state_r.en;
				end
				alt_pkg::STATUS_OFS: begin
					state_nxt.rdata[alt_pkg::DATA_W-1:0]        = state_r.acc;
					state_nxt.rdata[alt_pkg::STATUS_DONE_BIT]   = state_r.done;
					state_nxt.rdata[alt_pkg::STATUS_CARRY_BIT]  = state_r.carry;
				end
				default: begin
					state_nxt.rdata = alt_pkg::RST_RDATA;
				end
			endcase
		end
	end

	// ==================================================================
	// Registers.
	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			state_r.acc   <= alt_pkg::RST_ACC;
			state_r.carry <= alt_pkg::RST_CARRY;
			state_r.skip  <= alt_pkg::RST_SKIP;
			state_r.en    <= alt_pkg::RST_EN;
			state_r.done  <= alt_pkg::RST_DONE;
			state_r.rdata <= alt_pkg::RST_RDATA;
		end else begin
			state_r <= state_nxt;
		end
	end

	assign acc_o        = state_r.acc;
	assign carry_flag_o = state_r.carry;
	assign skip_o       = state_r.skip;
	assign xfer_done_o  = state_r.done;
	assign reg_rdata_o  = state_r.rdata;

	// ==================================================================
	// Assertions.
	logic ok_go;
	assign ok_go = instr_valid_i && state_r.en;

	a_int_one_load: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		ok_go && instr_i == alt_pkg::OP_READ_INT_CTRL_ONE |=> acc_o == $past(int_ctrl_reg_one_i))
		else $error("Interrupt control one not loaded.");

	a_int_two_load: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		ok_go && instr_i == alt_pkg::OP_READ_INT_CTRL_TWO |=> acc_o == $past(int_ctrl_reg_two_i))
		else $error("Interrupt control two not loaded.");

	a_tmr_one_load: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		ok_go && instr_i == alt_pkg::OP_READ_TIMER_CTRL_ONE |=> acc_o == $past(timer_ctrl_reg_one_i))
		else $error("Timer control one not loaded.");

	a_tmr_two_load: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		ok_go && instr_i == alt_pkg::OP_READ_TIMER_CTRL_TWO |=> acc_o == $past(timer_ctrl_reg_two_i))
		else $error("Timer control two not loaded.");

	a_tmr_three_load: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		ok_go && instr_i == alt_pkg::OP_READ_TIMER_CTRL_THREE |=> acc_o == $past(timer_ctrl_reg_three_i))
		else $error("Timer control three not loaded.");

	a_tmr_four_load: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		ok_go && instr_i == alt_pkg::OP_READ_TIMER_CTRL_FOUR |=> acc_o == $past(timer_ctrl_reg_four_i))
		else $error("Timer control four not loaded.");

	a_x_load: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		ok_go && instr_i == alt_pkg::OP_LOAD_ACC_FROM_X |=> acc_o == $past(reg_x_i) && xfer_done_o)
		else $error("Register X not loaded.");

	a_y_load: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		ok_go && instr_i == alt_pkg::OP_LOAD_ACC_FROM_Y |=> acc_o == $past(reg_y_i) && xfer_done_o)
		else $error("Register Y not loaded.");

	a_carry_skip_kept: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		hit |=> $stable(carry_flag_o) && !skip_o)
		else $error("Transfer changed carry or raised skip.");

	a_disabled_ignored: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		instr_valid_i && !state_r.en && !acc_wr_i |=> $stable(acc_o) && !xfer_done_o)
		else $error("Transfer taken while disabled.");

	a_done_after_hit: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		hit |=> xfer_done_o)
		else $error("Transfer taken without done.");

	a_hit_needs_enable: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		hit |-> instr_valid_i && state_r.en)
		else $error("Transfer decoded without a valid enabled instruction.");

	a_other_op_refused: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		instr_valid_i && alt_pkg::alt_decode_fn(instr_i) == alt_pkg::ALT_SRC_NONE |-> !hit)
		else $error("Unknown opcode taken as a transfer.");

	a_known_op_taken: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		ok_go && alt_pkg::alt_decode_fn(instr_i) != alt_pkg::ALT_SRC_NONE |-> hit)
		else $error("Known opcode not taken as a transfer.");

	a_src_idle_none: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!instr_valid_i |-> src == alt_pkg::ALT_SRC_NONE)
		else $error("Source selected without a valid instruction.");

	a_src_disabled_none: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!state_r.en |-> src == alt_pkg::ALT_SRC_NONE)
		else $error("Source selected while disabled.");

	// ==================================================================
	// Other instruction assertions.
	a_acc_write_taken: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!hit && acc_wr_i |=> acc_o == $past(acc_wr_data_i))
		else $error("Accumulator write not taken.");

	a_acc_held_idle: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!hit && !acc_wr_i |=> $stable(acc_o))
		else $error("Accumulator changed without a write.");

	a_carry_write_taken: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!hit && carry_wr_i |=> carry_flag_o == $past(carry_wr_data_i))
		else $error("Carry write not taken.");

	a_carry_held_idle: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		hit || !carry_wr_i |=> $stable(carry_flag_o))
		else $error("Carry changed without a carry write.");

	a_skip_follows_req: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!hit && skip_req_i |=> skip_o)
		else $error("Skip request not taken.");

	a_skip_clear_idle: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!hit && !skip_req_i |=> !skip_o)
		else $error("Skip raised without a request.");

	a_done_pulse_only: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!hit |=> !xfer_done_o)
		else $error("Done raised without a transfer.");

	// ==================================================================
	// Register port assertions.
	a_rdata_idle_zero: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!reg_re_i |=> reg_rdata_o == alt_pkg::RST_RDATA)
		else $error("Read data shown without a read.");

	a_rdata_ctrl_read: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		reg_re_i && reg_addr_i == alt_pkg::CTRL_OFS |=> reg_rdata_o[alt_pkg::CTRL_EN_BIT] == $past(state_r.en))
		else $error("Control read shows wrong enable.");

	a_rdata_ctrl_high: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		reg_re_i && reg_addr_i == alt_pkg::CTRL_OFS |=> reg_rdata_o[alt_pkg::REG_W-1:alt_pkg::CTRL_EN_BIT+1] == '0)
		else $error("Control read shows stray bits.");

	a_rdata_status_acc: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		reg_re_i && reg_addr_i == alt_pkg::STATUS_OFS |=> reg_rdata_o[alt_pkg::DATA_W-1:0] == $past(acc_o)
			&& reg_rdata_o[alt_pkg::STATUS_CARRY_BIT] == $past(carry_flag_o))
		else $error("Status read shows wrong accumulator or carry.");

	a_rdata_status_done: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		reg_re_i && reg_addr_i == alt_pkg::STATUS_OFS |=> reg_rdata_o[alt_pkg::STATUS_DONE_BIT] == $past(xfer_done_o)
			&& reg_rdata_o[alt_pkg::REG_W-1:alt_pkg::STATUS_CARRY_BIT+1] == '0)
		else $error("Status read shows wrong done or stray bits.");

	a_rdata_unmapped: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		reg_re_i && reg_addr_i != alt_pkg::CTRL_OFS && reg_addr_i != alt_pkg::STATUS_OFS
			|=> reg_rdata_o == alt_pkg::RST_RDATA)
		else $error("Unmapped read shows data.");

	a_enable_write: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		reg_we_i && reg_addr_i == alt_pkg::CTRL_OFS |=> state_r.en == $past(reg_wdata_i[alt_pkg::CTRL_EN_BIT]))
		else $error("Enable write not taken.");

	a_enable_held: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		!(reg_we_i && reg_addr_i == alt_pkg::CTRL_OFS) |=> $stable(state_r.en))
		else $error("Enable changed without a control write.");

	a_enable_other_kept: assert property (@(posedge clock_i) disable iff (sys_rst_i)
		reg_we_i && reg_addr_i != alt_pkg::CTRL_OFS |=> $stable(state_r.en))
		else $error("Unmapped write changed the enable.");

	// ==================================================================
	// Reset assertion.
	a_reset_clears: assert property (@(posedge clock_i)
		sys_rst_i |=> acc_o == alt_pkg::RST_ACC && carry_flag_o == alt_pkg::RST_CARRY && skip_o == alt_pkg::RST_SKIP
			&& xfer_done_o == alt_pkg::RST_DONE && state_r.en == alt_pkg::RST_EN)
		else $error("Reset values not applied.");

	// ==================================================================
	// Cover points.
	c_int_load: cover property (@(posedge clock_i) disable iff (sys_rst_i)
		src == alt_pkg::ALT_SRC_INT_ONE ##1 src == alt_pkg::ALT_SRC_INT_TWO);
	c_tmr_load: cover property (@(posedge clock_i) disable iff (sys_rst_i)
		src == alt_pkg::ALT_SRC_TMR_FOUR);
	c_x_then_y: cover property (@(posedge clock_i) disable iff (sys_rst_i)
		src == alt_pkg::ALT_SRC_X ##1 src == alt_pkg::ALT_SRC_Y);
	c_disabled_try: cover property (@(posedge clock_i) disable iff (sys_rst_i)
		instr_valid_i && !state_r.en);
	c_back_to_back: cover property (@(posedge clock_i) disable iff (sys_rst_i)
		hit ##1 hit);

endmodule : alt_core

`default_nettype wire

// file: core/alt_decode.sv
// Instruction decoder for the accumulator load transfers.
// Assumes instr_i is valid while valid_i is high; purely combinational.
`timescale 1ns/1ns
`default_nettype none

module alt_decode (
	input  wire logic [alt_pkg::INSTR_W-1:0] instr_i,
	input  wire logic                        valid_i,
	input  wire logic                        en_i,
	output var  alt_pkg::alt_src_t           src_o,
	output logic                             hit_o
);

	// ==================================================================
	// Decode.
	always_comb begin
		if (valid_i && en_i) begin
			src_o = alt_pkg::alt_decode_fn(instr_i);
		end else begin
			src_o = alt_pkg::ALT_SRC_NONE;
		end
	end

	assign hit_o = (src_o != alt_pkg::ALT_SRC_NONE);

endmodule : alt_decode

`default_nettype wire

// file: core/alt_pkg.sv
// Constants, types and the decode function of the accumulator load transfers.
// Assumes a 10-bit instruction word presented for one instruction cycle.
`default_nettype none

package alt_pkg;

	// ==================================================================
	// Widths.
	localparam int DATA_W  = 4;
	localparam int INSTR_W = 10;
	localparam int ADDR_W  = 2;
	localparam int REG_W   = 8;

	// ==================================================================
	// Opcodes.
	localparam logic [INSTR_W-1:0] OP_READ_INT_CTRL_ONE     = 10'h054;
	localparam logic [INSTR_W-1:0] OP_READ_INT_CTRL_TWO     = 10'h055;
	localparam logic [INSTR_W-1:0] OP_READ_TIMER_CTRL_ONE   = 10'h24b;
	localparam logic [INSTR_W-1:0] OP_READ_TIMER_CTRL_TWO   = 10'h24c;
	localparam logic [INSTR_W-1:0] OP_READ_TIMER_CTRL_THREE = 10'h24d;
	localparam logic [INSTR_W-1:0] OP_READ_TIMER_CTRL_FOUR  = 10'h24e;
	localparam logic [INSTR_W-1:0] OP_LOAD_ACC_FROM_X       = 10'h052;
	localparam logic [INSTR_W-1:0] OP_LOAD_ACC_FROM_Y       = 10'h01f;

	// ==================================================================
	// Register port map.
	localparam logic [ADDR_W-1:0] CTRL_OFS   = 2'h0;
	localparam logic [ADDR_W-1:0] STATUS_OFS = 2'h1;
	localparam int                CTRL_EN_BIT      = 0;
	localparam int                STATUS_DONE_BIT  = 4;
	localparam int                STATUS_CARRY_BIT = 5;

	// ==================================================================
	// Reset values.
	localparam logic [DATA_W-1:0] RST_ACC   = 4'h0;
	localparam logic              RST_CARRY = 1'h0;
	localparam logic              RST_SKIP  = 1'h0;
	localparam logic              RST_EN    = 1'h1;
	localparam logic              RST_DONE  = 1'h0;
	localparam logic [REG_W-1:0]  RST_RDATA = 8'h00;

	// ==================================================================
	// Types.
	typedef enum logic [3:0] {
		ALT_SRC_NONE,
		ALT_SRC_INT_ONE,
		ALT_SRC_INT_TWO,
		ALT_SRC_TMR_ONE,
		ALT_SRC_TMR_TWO,
		ALT_SRC_TMR_THREE,
		ALT_SRC_TMR_FOUR,
		ALT_SRC_X,
		ALT_SRC_Y
	} alt_src_t;

	typedef struct packed {
		logic [DATA_W-1:0] acc;
		logic              carry;
		logic              skip;
		logic              en;
		logic              done;
		logic [REG_W-1:0]  rdata;
	} alt_state_t;

	// ==================================================================
	// Opcode to source decode.
	function automatic alt_src_t alt_decode_fn(input logic [INSTR_W-1:0] op);
		case (op)
			OP_READ_INT_CTRL_ONE:     alt_decode_fn = ALT_SRC_INT_ONE;
			OP_READ_INT_CTRL_TWO:     alt_decode_fn = ALT_SRC_INT_TWO;
			OP_READ_TIMER_CTRL_ONE:   alt_decode_fn = ALT_SRC_TMR_ONE;
			OP_READ_TIMER_CTRL_TWO:   alt_decode_fn = ALT_SRC_TMR_TWO;
			OP_READ_TIMER_CTRL_THREE: alt_decode_fn = ALT_SRC_TMR_THREE;
			OP_READ_TIMER_CTRL_FOUR:  alt_decode_fn = ALT_SRC_TMR_FOUR;
			OP_LOAD_ACC_FROM_X:       alt_decode_fn = ALT_SRC_X;
			OP_LOAD_ACC_FROM_Y:       alt_decode_fn = ALT_SRC_Y;
			default:                  alt_decode_fn = ALT_SRC_NONE;
		endcase
	endfunction : alt_decode_fn

endpackage : alt_pkg

`default_nettype wire

// file: tb/accumulator_load_transfers_tb_top.sv
// Self-checking bench for the accumulator load transfers core.
// Assumes alt_core and alt_pkg are compiled first; drives all ports itself.
`timescale 1ns/1ns
`default_nettype none

module accumulator_load_transfers_tb_top;

	// ==================================================================
	// Signals.
	logic                        clock_i = 1'b0;
	logic                        sys_rst_i = 1'b1;
	logic [alt_pkg::INSTR_W-1:0] instr_i = '0;
	logic                        instr_valid_i = 1'b0;
	logic [alt_pkg::DATA_W-1:0]  src [8] = '{default: 4'h0};
	logic                        acc_wr_i = 1'b0;
	logic [alt_pkg::DATA_W-1:0]  acc_wr_data_i = 4'h0;
	logic                        carry_wr_i = 1'b0;
	logic                        carry_wr_data_i = 1'b0;
	logic                        skip_req_i = 1'b0;
	logic [alt_pkg::ADDR_W-1:0]  reg_addr_i = 2'h0;
	logic [alt_pkg::REG_W-1:0]   reg_wdata_i = 8'h00;
	logic                        reg_we_i = 1'b0;
	logic                        reg_re_i = 1'b0;
	logic [alt_pkg::REG_W-1:0]   reg_rdata_o;
	logic [alt_pkg::DATA_W-1:0]  acc_o;
	logic                        carry_flag_o;
	logic                        skip_o;
	logic                        xfer_done_o;
	logic [alt_pkg::REG_W-1:0]   rd_data;
	logic [alt_pkg::DATA_W-1:0]  acc_keep;
	int                          mismatches = 0;
	int                          checks_done = 0;
	int                          cycles = 0;
	logic [alt_pkg::INSTR_W-1:0] ops [8] = '{alt_pkg::OP_READ_INT_CTRL_ONE, alt_pkg::OP_READ_INT_CTRL_TWO,
		alt_pkg::OP_READ_TIMER_CTRL_ONE, alt_pkg::OP_READ_TIMER_CTRL_TWO, alt_pkg::OP_READ_TIMER_CTRL_THREE,
		alt_pkg::OP_READ_TIMER_CTRL_FOUR, alt_pkg::OP_LOAD_ACC_FROM_X, alt_pkg::OP_LOAD_ACC_FROM_Y};

	always #50 clock_i = ~clock_i;

	alt_core alt_core_i (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i), .instr_i(instr_i), .instr_valid_i(instr_valid_i),
		.int_ctrl_reg_one_i(src[0]), .int_ctrl_reg_two_i(src[1]), .timer_ctrl_reg_one_i(src[2]),
		.timer_ctrl_reg_two_i(src[3]), .timer_ctrl_reg_three_i(src[4]), .timer_ctrl_reg_four_i(src[5]),
		.reg_x_i(src[6]), .reg_y_i(src[7]), .acc_wr_i(acc_wr_i), .acc_wr_data_i(acc_wr_data_i),
		.carry_wr_i(carry_wr_i), .carry_wr_data_i(carry_wr_data_i), .skip_req_i(skip_req_i),
		.reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_we_i(reg_we_i), .reg_re_i(reg_re_i),
		.reg_rdata_o(reg_rdata_o), .acc_o(acc_o), .carry_flag_o(carry_flag_o), .skip_o(skip_o),
		.xfer_done_o(xfer_done_o)
	);

	// ==================================================================
	// Tasks.
	task automatic test_done;
		$display("checks %0d, mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : test_done

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		checks_done++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch at %0t: %s got %h expected %h", $time, msg, got, exp);
		end
	endtask : chk

	task automatic wr(input logic [1:0] addr, input logic [7:0] data);
		@(posedge clock_i);
		reg_we_i    <= 1'b1;
		reg_addr_i  <= addr;
		reg_wdata_i <= data;
		@(posedge clock_i);
		reg_we_i    <= 1'b0;
	endtask : wr

	task automatic rd(input logic [1:0] addr, output logic [7:0] data);
		@(posedge clock_i);
		reg_re_i   <= 1'b1;
		reg_addr_i <= addr;
		@(posedge clock_i);
		reg_re_i   <= 1'b0;
		#1;
		data = reg_rdata_o;
	endtask : rd

	// Side high also raises competing accumulator, carry and skip requests.
	task automatic issue(input logic [9:0] op, input logic side);
		@(posedge clock_i);
		instr_i         <= op;
		instr_valid_i   <= 1'b1;
		acc_wr_i        <= side;
		carry_wr_i      <= side;
		carry_wr_data_i <= 1'b0;
		skip_req_i      <= side;
		@(posedge clock_i);
		instr_valid_i   <= 1'b0;
		acc_wr_i        <= 1'b0;
		carry_wr_i      <= 1'b0;
		skip_req_i      <= 1'b0;
		#1;
	endtask : issue

	always @(posedge clock_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			mismatches++;
			$display("mismatch at %0t: run timed out", $time);
			test_done();
		end
	end

	// ==================================================================
	// Main sequence.
	initial begin
		repeat (5) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		#1;
		chk(acc_o, 8'h00, "acc after reset");
		chk({carry_flag_o, skip_o, xfer_done_o}, 8'h00, "flags after reset");
		rd(alt_pkg::CTRL_OFS, rd_data);
		chk(rd_data, 8'h01, "ctrl reset value");
		@(posedge clock_i);
		#1;
		chk(reg_rdata_o, 8'h00, "read data one cycle");
		wr(2'h2, 8'hff);
		rd(2'h2, rd_data);
		chk(rd_data, 8'h00, "unmapped read");
		$display("test reset and registers done");
		@(posedge clock_i);
		carry_wr_i      <= 1'b1;
		carry_wr_data_i <= 1'b1;
		@(posedge clock_i);
		carry_wr_i      <= 1'b0;
		#1;
		chk(carry_flag_o, 8'h01, "carry set");
		for (int pass = 0; pass < 2; pass++) begin
			for (int i = 0; i < 8; i++) begin
				for (int k = 0; k < 8; k++) src[k] <= 4'(k * 5 + 3) ^ {4{pass[0]}};
				issue(ops[i], pass[0]);
				chk(acc_o, 4'(i * 5 + 3) ^ {4{pass[0]}}, "transfer value");
				chk({carry_flag_o, skip_o, xfer_done_o}, 8'h05, "carry skip done");
			end
		end
		@(posedge clock_i);
		#1;
		chk(xfer_done_o, 8'h00, "done one cycle");
		$display("test all opcodes done");
		@(posedge clock_i);
		src[6]        <= 4'h9;
		src[7]        <= 4'h4;
		instr_i       <= alt_pkg::OP_LOAD_ACC_FROM_X;
		instr_valid_i <= 1'b1;
		@(posedge clock_i);
		instr_i       <= alt_pkg::OP_LOAD_ACC_FROM_Y;
		#1;
		chk(acc_o, 8'h09, "back to back x");
		@(posedge clock_i);
		instr_valid_i <= 1'b0;
		#1;
		chk(acc_o, 8'h04, "back to back y");
		rd(alt_pkg::STATUS_OFS, rd_data);
		chk(rd_data, 8'h24, "status acc carry done");
		$display("test back to back done");
		wr(alt_pkg::CTRL_OFS, 8'h00);
		rd(alt_pkg::CTRL_OFS, rd_data);
		chk(rd_data, 8'h00, "ctrl cleared");
		acc_keep = acc_o;
		src[6] <= 4'ha;
		issue(alt_pkg::OP_LOAD_ACC_FROM_X, 1'b0);
		chk({acc_o, 3'h0, xfer_done_o}, {acc_keep, 4'h0}, "disabled refused");
		wr(alt_pkg::CTRL_OFS, 8'h01);
		issue(10'h3ff, 1'b0);
		chk({acc_o, 3'h0, xfer_done_o}, {acc_keep, 4'h0}, "other opcode refused");
		$display("test refusals done");
		@(posedge clock_i);
		sys_rst_i <= 1'b1;
		repeat (2) @(posedge clock_i);
		sys_rst_i <= 1'b0;
		#1;
		chk({acc_o, 2'h0, carry_flag_o, xfer_done_o}, 8'h00, "mid run reset");
		rd(alt_pkg::CTRL_OFS, rd_data);
		chk(rd_data, 8'h01, "enable after mid run reset");
		issue(alt_pkg::OP_LOAD_ACC_FROM_X, 1'b0);
		chk({acc_o, 3'h0, xfer_done_o}, 8'ha1, "transfer after mid run reset");
		$display("test mid run reset done");
		test_done();
	end

endmodule : accumulator_load_transfers_tb_top

`default_nettype wire
